// file: hw/rsim_core.sv
// return stack and indirect-address mapper of the cpu core
// assumes a sequencer that issues one push or pop per cycle, and data
// memory / flash that answer reads within the cycle in which the request stands
// Functional notes
// - sixteen fifteen-bit return entries, own storage
// - push pc on call, computed call, interrupt
// - pop restores pc on returns
// - push and pop leave pc latch alone
// - fault reset off: stack wraps circularly
// - fault flags set regardless of reset enable
// - software reaches entries via pointer and top
// - pointer is five bits wide
// - push increments then writes; pop reads then decrements
// - empty is 0x1f; one push gives 0x00
// - fault reset on: overflow/underflow resets device
// - indirect port access goes to pointer target
// - pointer at indirect port: read zero, no write
// - pointer is sixteen bits from two bytes
// - 0x0000-0x1fff map to absolute addresses
// - linear region walks 80-byte ram blocks
// - unimplemented linear reads return zero
// - common memory excluded from linear region
// - msb set selects flash, low byte returned
// - indirect writes to flash are dropped
// - flash reads take one extra cycle
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rsim_map.svh"
module rsim_core #(
    parameter int LIN_BANKS = 51
) (
    input  wire logic                      I_CORE_CLK,
    input  wire logic                      I_RESET,
    input  wire rsim_pkg::rsim_op_type     I_STK_OP,
    input  wire logic [14:0]               I_PC,
    input  wire rsim_pkg::rsim_ind_req_type I_IND_REQ,
    input  wire logic [7:0]                I_DATA_RDATA,
    input  wire logic [13:0]               I_FLASH_RDATA,
    input  wire logic [7:0]                I_REG_ADDR,
    input  wire logic [7:0]                I_REG_WDATA,
    input  wire logic                      I_REG_WR,
    input  wire logic                      I_REG_RD,
    output var  logic [7:0]                O_REG_RDATA,
    output var  logic [14:0]               O_RET_PC,
    output var  logic                      O_RET_VALID,
    output var  logic                      O_FAULT_RESET,
    output var  rsim_pkg::rsim_mem_req_type O_MEM_REQ,
    output var  logic [7:0]                O_IND_RDATA,
    output var  logic                      O_IND_DONE,
    output var  logic                      O_IND_STALL,
    output var  logic [6:0]                O_PC_HIGH_LATCH
);
    // elaboration guard: the linear window never reaches past 51 banks
    if (LIN_BANKS < 1 || LIN_BANKS > 51) begin : g_bad_banks
        $error("LIN_BANKS out of range");
    end

    // storage and pointer
    logic [`RSIM_PC_W-1:0] stack_mem [`RSIM_STK_DEPTH];
    logic [4:0]  stack_pointer_r;
    logic [4:0]  ptr_nxt;
    logic        ovf_flag_r;
    logic        unf_flag_r;
    logic        fault_reset_en_r;
    logic [7:0]  fsel_low_r [2];
    logic [7:0]  fsel_high_r [2];
    logic [6:0]  pc_high_latch_r;
    logic        ind_pend_r;
    logic        ind_flash_r;
    logic        ind_zero_r;
    logic        is_push;
    logic        is_pop;
    logic        ovf_evt;
    logic        unf_evt;
    logic [3:0]  sel_idx;

    assign is_push = (I_STK_OP == rsim_pkg::RSIM_OP_PUSH);
    assign is_pop  = (I_STK_OP == rsim_pkg::RSIM_OP_POP);
    // full means pointer already at top entry
    assign ovf_evt = is_push && (stack_pointer_r == `RSIM_PTR_TOP);
    assign unf_evt = is_pop && (stack_pointer_r == `RSIM_PTR_EMPTY);
    assign sel_idx = stack_pointer_r[3:0];

    // pointer next value; 0x1f+1 wraps to 0x00 naturally
    always_comb begin
        ptr_nxt = stack_pointer_r;
        if (is_push) begin
            ptr_nxt = (stack_pointer_r == `RSIM_PTR_TOP) ? 5'h00 : stack_pointer_r + 5'h01;
        end else if (is_pop) begin
            ptr_nxt = (stack_pointer_r == 5'h00) ? `RSIM_PTR_EMPTY : stack_pointer_r - 5'h01;
        end
    end

    // pointer: sequencer ops win over software writes
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            stack_pointer_r <= `RSIM_PTR_EMPTY;
        end else if (is_push || is_pop) begin
            stack_pointer_r <= ptr_nxt;
        end else if (I_REG_WR && I_REG_ADDR == `RSIM_OFS_PTR) begin
            stack_pointer_r <= I_REG_WDATA[4:0];
        end
    end

    // entry writes; push stores at the incremented slot
    always_ff @(posedge I_CORE_CLK) begin
        if (is_push) begin
            stack_mem[ptr_nxt[3:0]] <= I_PC;
        end else if (I_REG_WR && I_REG_ADDR == `RSIM_OFS_TOP_OF_STACK_LOW) begin
            stack_mem[sel_idx] <= {stack_mem[sel_idx][14:8], I_REG_WDATA};
        end else if (I_REG_WR && I_REG_ADDR == `RSIM_OFS_TOP_OF_STACK_HIGH) begin
            stack_mem[sel_idx] <= {I_REG_WDATA[6:0], stack_mem[sel_idx][7:0]};
        end
    end

    // pop reads the current slot before the pointer moves
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_RET_PC    <= 15'h0000;
            O_RET_VALID <= 1'b0;
        end else begin
            O_RET_VALID <= is_pop;
            if (is_pop) begin
                O_RET_PC <= stack_mem[sel_idx];
            end
        end
    end

    // fault flags: hardware set wins over software clear
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ovf_flag_r <= 1'b0;
            unf_flag_r <= 1'b0;
        end else begin
            if (ovf_evt) begin
                ovf_flag_r <= 1'b1;
            end else if (I_REG_WR && I_REG_ADDR == `RSIM_OFS_STATUS
                         && !I_REG_WDATA[`RSIM_BIT_OVF]) begin
                ovf_flag_r <= 1'b0;
            end
            if (unf_evt) begin
                unf_flag_r <= 1'b1;
            end else if (I_REG_WR && I_REG_ADDR == `RSIM_OFS_STATUS
                         && !I_REG_WDATA[`RSIM_BIT_UNF]) begin
                unf_flag_r <= 1'b0;
            end
        end
    end

    // fault reset request is a one-cycle pulse to the reset logic
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_FAULT_RESET <= 1'b0;
        end else begin
            O_FAULT_RESET <= fault_reset_en_r && (ovf_evt || unf_evt);
        end
    end

    // control register; flags live outside this reset in a real chip
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            fault_reset_en_r <= 1'b0;
        end else if (I_REG_WR && I_REG_ADDR == `RSIM_OFS_CTRL) begin
            fault_reset_en_r <= I_REG_WDATA[`RSIM_BIT_FRE];
        end
    end

    // pc latch: untouched by stack activity
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            pc_high_latch_r <= 7'h00;
        end else if (I_REG_WR && I_REG_ADDR == `RSIM_OFS_PC_HIGH_LATCH) begin
            pc_high_latch_r <= I_REG_WDATA[6:0];
        end
    end

    // output copy loads with the latch, so it never lags a write
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PC_HIGH_LATCH <= 7'h00;
        end else if (I_REG_WR && I_REG_ADDR == `RSIM_OFS_PC_HIGH_LATCH) begin
            O_PC_HIGH_LATCH <= I_REG_WDATA[6:0];
        end
    end

    // file select pointers, two pairs of bytes
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            fsel_low_r[0]  <= 8'h00;
            fsel_low_r[1]  <= 8'h00;
            fsel_high_r[0] <= 8'h00;
            fsel_high_r[1] <= 8'h00;
        end else if (I_REG_WR) begin
            unique case (I_REG_ADDR)
                `RSIM_OFS_FSEL0L: fsel_low_r[0]  <= I_REG_WDATA;
                `RSIM_OFS_FSEL0H: fsel_high_r[0] <= I_REG_WDATA;
                `RSIM_OFS_FSEL1L: fsel_low_r[1]  <= I_REG_WDATA;
                `RSIM_OFS_FSEL1H: fsel_high_r[1] <= I_REG_WDATA;
                default: ;
            endcase
        end
    end

    // region decode of a 16-bit pointer
    function automatic rsim_pkg::rsim_region_type region_of(input logic [15:0] a);
        logic [15:0] lim;
        lim = 16'(`RSIM_LIN_BASE + LIN_BANKS * `RSIM_GPR_BYTES - 1);
        if (a[15]) begin
            region_of = rsim_pkg::RSIM_REG_FLASH;
        end else if (a <= `RSIM_BANK_TOP) begin
            region_of = rsim_pkg::RSIM_REG_BANKED;
        end else if (a <= `RSIM_LIN_TOP && a <= lim) begin
            region_of = rsim_pkg::RSIM_REG_LINEAR;
        end else begin
            region_of = rsim_pkg::RSIM_REG_NONE;
        end
    endfunction : region_of

    // linear offset to absolute address: bank*128 + 0x20 + offset,
    // skipping the common bytes at the bank tail
    function automatic logic [12:0] lin_to_abs(input logic [15:0] a);
        logic [11:0] off;
        logic [5:0]  bank;
        logic [6:0]  inb;
        off  = a[11:0];
        bank = 6'(off / 12'(`RSIM_GPR_BYTES));
        inb  = 7'(off % 12'(`RSIM_GPR_BYTES));
        lin_to_abs = {bank, 7'h00} + 13'(`RSIM_GPR_OFS + inb);
    endfunction : lin_to_abs

    logic [15:0]                 cur_ptr;
    rsim_pkg::rsim_region_type   cur_reg;
    logic                        self_hit;
    logic [12:0]                 cur_abs;

    // pointer formed from the selected byte pair
    assign cur_ptr  = {fsel_high_r[I_IND_REQ.sel], fsel_low_r[I_IND_REQ.sel]};
    assign cur_reg  = region_of(cur_ptr);
    assign cur_abs  = (cur_reg == rsim_pkg::RSIM_REG_LINEAR) ? lin_to_abs(cur_ptr)
                                                              : cur_ptr[12:0];
    assign self_hit = (cur_reg != rsim_pkg::RSIM_REG_FLASH)
                      && (cur_reg != rsim_pkg::RSIM_REG_NONE)
                      && (cur_abs == `RSIM_IDP0_ADDR || cur_abs == `RSIM_IDP1_ADDR);

    // issue memory access for an indirect port access
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_MEM_REQ   <= '0;
            ind_pend_r  <= 1'b0;
            ind_flash_r <= 1'b0;
            ind_zero_r  <= 1'b0;
        end else begin
            O_MEM_REQ   <= '0;
            ind_pend_r  <= I_IND_REQ.valid && !O_IND_STALL;
            ind_flash_r <= 1'b0;
            ind_zero_r  <= 1'b0;
            if (I_IND_REQ.valid && !O_IND_STALL) begin
                ind_zero_r <= self_hit || cur_reg == rsim_pkg::RSIM_REG_NONE
                              || I_IND_REQ.write;
                if (cur_reg == rsim_pkg::RSIM_REG_FLASH) begin
                    ind_flash_r <= !I_IND_REQ.write;
                    O_MEM_REQ.flash_rd   <= !I_IND_REQ.write;
                    O_MEM_REQ.flash_addr <= cur_ptr[14:0];
                end else if (!self_hit && cur_reg != rsim_pkg::RSIM_REG_NONE) begin
                    O_MEM_REQ.data_addr  <= cur_abs;
                    O_MEM_REQ.data_rd    <= !I_IND_REQ.write;
                    O_MEM_REQ.data_wr    <= I_IND_REQ.write;
                    O_MEM_REQ.data_wdata <= I_IND_REQ.wdata;
                end
            end
        end
    end

    // completion; flash reads hold the sequencer one extra cycle
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_IND_RDATA <= 8'h00;
            O_IND_DONE  <= 1'b0;
            O_IND_STALL <= 1'b0;
        end else begin
            O_IND_DONE  <= 1'b0;
            O_IND_STALL <= 1'b0;
            if (ind_pend_r && ind_flash_r && !O_IND_STALL) begin
                O_IND_STALL <= 1'b1;
                O_IND_RDATA <= I_FLASH_RDATA[7:0];
            end else if (O_IND_STALL) begin
                O_IND_DONE  <= 1'b1;
            end else if (ind_pend_r) begin
                O_IND_DONE  <= 1'b1;
                O_IND_RDATA <= ind_zero_r ? 8'h00 : I_DATA_RDATA;
            end
        end
    end

    // register read port, data one cycle after strobe
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_REG_RDATA <= 8'h00;
        end else if (I_REG_RD) begin
            unique case (I_REG_ADDR)
                `RSIM_OFS_PTR:    O_REG_RDATA <= {3'h0, stack_pointer_r};
                `RSIM_OFS_TOP_OF_STACK_LOW:   O_REG_RDATA <= stack_mem[sel_idx][7:0];
                `RSIM_OFS_TOP_OF_STACK_HIGH:   O_REG_RDATA <= {1'b0, stack_mem[sel_idx][14:8]};
                `RSIM_OFS_STATUS: O_REG_RDATA <= {6'h00, unf_flag_r, ovf_flag_r};
                `RSIM_OFS_CTRL:   O_REG_RDATA <= {7'h00, fault_reset_en_r};
                `RSIM_OFS_FSEL0L: O_REG_RDATA <= fsel_low_r[0];
                `RSIM_OFS_FSEL0H: O_REG_RDATA <= fsel_high_r[0];
                `RSIM_OFS_FSEL1L: O_REG_RDATA <= fsel_low_r[1];
                `RSIM_OFS_FSEL1H: O_REG_RDATA <= fsel_high_r[1];
                `RSIM_OFS_PC_HIGH_LATCH: O_REG_RDATA <= {1'b0, pc_high_latch_r};
                default:          O_REG_RDATA <= 8'h00;
            endcase
        end else begin
            O_REG_RDATA <= 8'h00;
        end
    end
endmodule : rsim_core
`default_nettype wire

// file: shared/rsim_map.svh
// constants for the return stack and indirect mapper
// assumes inclusion by bare name from the package and the design
`ifndef RSIM_MAP_SVH
`define RSIM_MAP_SVH
`define RSIM_STK_DEPTH       16
`define RSIM_PC_W            15
`define RSIM_PTR_EMPTY       5'h1f
`define RSIM_PTR_TOP         5'h0f
`define RSIM_OFS_PTR         8'h00
`define RSIM_OFS_TOP_OF_STACK_LOW        8'h01
`define RSIM_OFS_TOP_OF_STACK_HIGH        8'h02
`define RSIM_OFS_STATUS      8'h03
`define RSIM_OFS_CTRL        8'h04
`define RSIM_OFS_FSEL0L      8'h05
`define RSIM_OFS_FSEL0H      8'h06
`define RSIM_OFS_FSEL1L      8'h07
`define RSIM_OFS_FSEL1H      8'h08
`define RSIM_OFS_PC_HIGH_LATCH      8'h09
`define RSIM_BANK_TOP        16'h1fff
`define RSIM_LIN_BASE        16'h2000
`define RSIM_LIN_TOP         16'h2fef
`define RSIM_GPR_BYTES       7'h50
`define RSIM_GPR_OFS         7'h20
`define RSIM_BANK_SIZE       7'h80
`define RSIM_IDP0_ADDR       13'h0000
`define RSIM_IDP1_ADDR       13'h0001
`define RSIM_BIT_OVF         0
`define RSIM_BIT_UNF         1
`define RSIM_BIT_FRE         0
`endif

// file: shared/rsim_pkg.sv
// types for the return stack and indirect mapper
// assumes the map header is on the include path
`include "rsim_map.svh"
package rsim_pkg;
    // stack operation requested by the sequencer
    typedef enum logic [1:0] {
        RSIM_OP_NONE,
        RSIM_OP_PUSH,
        RSIM_OP_POP
    } rsim_op_type;

    // target region of an indirect access
    typedef enum logic [1:0] {
        RSIM_REG_BANKED,
        RSIM_REG_LINEAR,
        RSIM_REG_FLASH,
        RSIM_REG_NONE
    } rsim_region_type;

    // indirect access request from the sequencer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        sel;
        logic [7:0]  wdata;
    } rsim_ind_req_type;

    // memory access issued toward data memory or flash
    typedef struct packed {
        logic        data_rd;
        logic        data_wr;
        logic [12:0] data_addr;
        logic [7:0]  data_wdata;
        logic        flash_rd;
        logic [14:0] flash_addr;
    } rsim_mem_req_type;
endpackage : rsim_pkg

// file: bench/rsim_core_monitor.sv
// concurrent checks on the return stack and indirect mapper ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rsim_core_monitor #(
    parameter int LIN_BANKS = 51
) (
    input  wire logic                       I_CORE_CLK,
    input  wire logic                       I_RESET,
    input  wire rsim_pkg::rsim_op_type      I_STK_OP,
    input  wire rsim_pkg::rsim_ind_req_type I_IND_REQ,
    input  wire logic [7:0]                 I_REG_ADDR,
    input  wire logic                       I_REG_WR,
    input  wire logic                       I_REG_RD,
    input  wire logic [7:0]                 O_REG_RDATA,
    input  wire logic                       O_RET_VALID,
    input  wire logic                       O_FAULT_RESET,
    input  wire rsim_pkg::rsim_mem_req_type O_MEM_REQ,
    input  wire logic                       O_IND_DONE,
    input  wire logic                       O_IND_STALL,
    input  wire logic [6:0]                 O_PC_HIGH_LATCH
);
    // everything runs on the core clock and is void while reset is up
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RESET);

    a_pop_answer: assert property (
        I_STK_OP == rsim_pkg::RSIM_OP_POP |=> O_RET_VALID)
        else $error("pop gave no return pc");
    a_ret_cause: assert property (
        O_RET_VALID |-> $past(I_STK_OP) == rsim_pkg::RSIM_OP_POP)
        else $error("return pc without pop");
    a_latch_hold: assert property (
        I_STK_OP != rsim_pkg::RSIM_OP_NONE && !(I_REG_WR && I_REG_ADDR == 8'h09)
        |=> $stable(O_PC_HIGH_LATCH)) else $error("stack op moved pc latch");
    a_read_idle: assert property (
        !I_REG_RD |=> O_REG_RDATA == 8'h00)
        else $error("read data without read strobe");
    a_ptr_width: assert property (
        I_REG_RD && I_REG_ADDR == 8'h00 |=> O_REG_RDATA[7:5] == 3'b000)
        else $error("pointer wider than five bits");
    a_flash_nowr: assert property (
        O_MEM_REQ.flash_rd |-> !$past(I_IND_REQ.write))
        else $error("flash access from a write");
    a_flash_slow: assert property (
        O_MEM_REQ.flash_rd |=> O_IND_STALL && !O_IND_DONE ##1 O_IND_DONE)
        else $error("flash read lacks extra cycle");
    a_data_fast: assert property (
        O_MEM_REQ.data_rd |=> O_IND_DONE && !O_IND_STALL)
        else $error("data read not done in time");
    a_self_skip: assert property (
        O_MEM_REQ.data_wr |-> O_MEM_REQ.data_addr > 13'h0001)
        else $error("write reached indirect port");
    a_fault_cause: assert property (
        O_FAULT_RESET |-> $past(I_STK_OP) != rsim_pkg::RSIM_OP_NONE)
        else $error("fault reset without stack op");
endmodule : rsim_core_monitor

bind rsim_core rsim_core_monitor #(.LIN_BANKS(LIN_BANKS)) u_rsim_core_monitor (
    .I_CORE_CLK, .I_RESET, .I_STK_OP, .I_IND_REQ, .I_REG_ADDR, .I_REG_WR,
    .I_REG_RD, .O_REG_RDATA, .O_RET_VALID, .O_FAULT_RESET, .O_MEM_REQ,
    .O_IND_DONE, .O_IND_STALL, .O_PC_HIGH_LATCH
);
`default_nettype wire

// file: bench/rsim_mem_model.sv
// data memory and program flash facing the mapper
// assumes requests are one-cycle pulses, answered while they stand
`timescale 1ns/1ps
`default_nettype none
module rsim_mem_model (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire rsim_pkg::rsim_mem_req_type i_req,
    output var  logic [7:0]                 o_data_rdata,
    output var  logic [13:0]                o_flash_rdata
);
    logic [7:0]  idle_data_r;
    logic [13:0] idle_flash_r;

    // idle lines toggle so a mistimed sample never sees valid data
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            idle_data_r  <= 8'h00;
            idle_flash_r <= 14'h0000;
        end else begin
            idle_data_r  <= ~idle_data_r;
            idle_flash_r <= ~idle_flash_r;
        end
    end

    // mapper samples the answer at the edge that ends its request cycle
    always_comb begin
        o_data_rdata  = i_req.data_rd ? (i_req.data_addr[7:0] ^ 8'h3c) : idle_data_r;
        // high bits set so a mapper passing them on is caught
        o_flash_rdata = i_req.flash_rd ? {6'h2a, i_req.flash_addr[7:0] ^ 8'hc3}
                                       : idle_flash_r;
    end
endmodule : rsim_mem_model
`default_nettype wire

// file: bench/tb_return_stack_and_indirect_mapper.sv
// self-checking bench for the return stack and indirect mapper
// assumes the package, the map header and the memory model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_return_stack_and_indirect_mapper;
    logic                       I_CORE_CLK  = 1'b0;
    logic                       I_RESET     = 1'b1;
    rsim_pkg::rsim_op_type      I_STK_OP    = rsim_pkg::RSIM_OP_NONE;
    logic [14:0]                I_PC        = 15'h0000;
    rsim_pkg::rsim_ind_req_type I_IND_REQ   = '0;
    logic [7:0]                 I_REG_ADDR  = 8'h00;
    logic [7:0]                 I_REG_WDATA = 8'h00;
    logic                       I_REG_WR    = 1'b0;
    logic                       I_REG_RD    = 1'b0;
    wire  logic [7:0]           I_DATA_RDATA;
    wire  logic [13:0]          I_FLASH_RDATA;
    logic [7:0]                 O_REG_RDATA;
    logic [14:0]                O_RET_PC;
    logic                       O_RET_VALID;
    logic                       O_FAULT_RESET;
    rsim_pkg::rsim_mem_req_type O_MEM_REQ;
    logic [7:0]                 O_IND_RDATA;
    logic                       O_IND_DONE;
    logic                       O_IND_STALL;
    logic [6:0]                 O_PC_HIGH_LATCH;
    int                         bad_count = 0;
    int                         checks    = 0;
    rsim_pkg::rsim_mem_req_type mq;
    int                         n;
    logic                       st;

    // four banks only, so the top of the linear window is unimplemented
    rsim_core #(.LIN_BANKS(4)) u_rsim_core (
        .I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_STK_OP(I_STK_OP), .I_PC(I_PC),
        .I_IND_REQ(I_IND_REQ), .I_DATA_RDATA(I_DATA_RDATA), .I_FLASH_RDATA(I_FLASH_RDATA),
        .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR),
        .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .O_RET_PC(O_RET_PC),
        .O_RET_VALID(O_RET_VALID), .O_FAULT_RESET(O_FAULT_RESET), .O_MEM_REQ(O_MEM_REQ),
        .O_IND_RDATA(O_IND_RDATA), .O_IND_DONE(O_IND_DONE), .O_IND_STALL(O_IND_STALL),
        .O_PC_HIGH_LATCH(O_PC_HIGH_LATCH));
    rsim_mem_model u_rsim_mem_model (.i_clk(I_CORE_CLK), .i_rst(I_RESET), .i_req(O_MEM_REQ),
        .o_data_rdata(I_DATA_RDATA), .o_flash_rdata(I_FLASH_RDATA));

    always #5 I_CORE_CLK = ~I_CORE_CLK;

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_CORE_CLK);
        I_REG_WR    <= 1'b1;
        I_REG_ADDR  <= a;
        I_REG_WDATA <= d;
        @(posedge I_CORE_CLK);
        I_REG_WR    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge I_CORE_CLK);
        I_REG_RD   <= 1'b1;
        I_REG_ADDR <= a;
        @(posedge I_CORE_CLK);
        I_REG_RD   <= 1'b0;
        #1 chk("reg", {8'h00, e}, {8'h00, O_REG_RDATA});
    endtask : rd

    task automatic stk(input rsim_pkg::rsim_op_type op, input logic [14:0] pc);
        @(posedge I_CORE_CLK);
        I_STK_OP <= op;
        I_PC     <= pc;
        @(posedge I_CORE_CLK);
        I_STK_OP <= rsim_pkg::RSIM_OP_NONE;
        #1;
    endtask : stk

    task automatic pop(input logic [14:0] e);
        stk(rsim_pkg::RSIM_OP_POP, 15'h0000);
        chk("ret_valid", 16'h0001, {15'h0000, O_RET_VALID});
        chk("ret_pc", {1'b0, e}, {1'b0, O_RET_PC});
    endtask : pop

    // one indirect access; n counts cycles to done, st records a stall
    task automatic ind(input logic s, input logic w, input logic [7:0] wd);
        @(posedge I_CORE_CLK);
        I_IND_REQ <= {1'b1, w, s, wd};
        @(posedge I_CORE_CLK);
        I_IND_REQ <= '0;
        #1 mq = O_MEM_REQ;
        n  = 1;
        st = 1'b0;
        while (O_IND_DONE !== 1'b1 && n < 6) begin
            @(posedge I_CORE_CLK);
            #1 n++;
            st |= O_IND_STALL;
        end
    endtask : ind

    // k is {data_rd, data_wr, flash_rd}
    task automatic go(input logic [15:0] p, input logic s, input logic w, input logic [2:0] k,
                      input logic [14:0] a, input logic [7:0] d);
        wr(s ? 8'h07 : 8'h05, p[7:0]);
        wr(s ? 8'h08 : 8'h06, p[15:8]);
        ind(s, w, 8'h9e);
        chk("kind", {13'h0000, k}, {13'h0000, mq.data_rd, mq.data_wr, mq.flash_rd});
        if (k != 3'b000)
            chk("addr", {1'b0, a}, {1'b0, k[0] ? mq.flash_addr : {2'b00, mq.data_addr}});
        if (k[1])
            chk("wdata", 16'h009e, {8'h00, mq.data_wdata});
        if (!w)
            chk("rdata", {8'h00, d}, {8'h00, O_IND_RDATA});
        if (!w)
            chk("cycles", k[0] ? 16'h0003 : 16'h0002, n[15:0]);
        chk("stall", {15'h0000, k[0]}, {15'h0000, st});
    endtask : go

    task automatic t_stack();
        rd(8'h00, 8'h1f);
        rd(8'h03, 8'h00);
        wr(8'h09, 8'h55);
        stk(rsim_pkg::RSIM_OP_PUSH, 15'h4a3c);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h3c);
        rd(8'h02, 8'h4a);
        pop(15'h4a3c);
        rd(8'h00, 8'h1f);
        rd(8'h09, 8'h55);
        chk("pc_high_latch", 16'h0055, {9'h000, O_PC_HIGH_LATCH});
        // rewrite an entry through the top-of-stack window
        stk(rsim_pkg::RSIM_OP_PUSH, 15'h1111);
        wr(8'h01, 8'h22);
        wr(8'h02, 8'h33);
        pop(15'h3322);
    endtask : t_stack

    task automatic t_wrap();
        for (int i = 0; i < 17; i++)
            stk(rsim_pkg::RSIM_OP_PUSH, 15'(i + 15'h0100));
        chk("fault", 16'h0000, {15'h0000, O_FAULT_RESET});
        rd(8'h00, 8'h00);
        rd(8'h03, 8'h01);
        pop(15'h0110);
        stk(rsim_pkg::RSIM_OP_POP, 15'h0000);
        rd(8'h00, 8'h1e);
        rd(8'h03, 8'h03);
        wr(8'h03, 8'h00);
        // fault reset enabled: both directions pulse the reset
        wr(8'h04, 8'h01);
        wr(8'h00, 8'h0f);
        stk(rsim_pkg::RSIM_OP_PUSH, 15'h0abc);
        chk("fault", 16'h0001, {15'h0000, O_FAULT_RESET});
        rd(8'h03, 8'h01);
        wr(8'h00, 8'h1f);
        stk(rsim_pkg::RSIM_OP_POP, 15'h0000);
        chk("fault", 16'h0001, {15'h0000, O_FAULT_RESET});
        rd(8'h03, 8'h03);
        wr(8'h04, 8'h00);
        wr(8'h03, 8'h00);
        rd(8'h03, 8'h00);
    endtask : t_wrap

    task automatic t_indirect();
        go(16'h0123, 1'b0, 1'b0, 3'b100, 15'h0123, 8'h23 ^ 8'h3c);
        go(16'h1a05, 1'b1, 1'b1, 3'b010, 15'h1a05, 8'h00);
        go(16'h204f, 1'b0, 1'b0, 3'b100, 15'h006f, 8'h6f ^ 8'h3c);
        go(16'h2050, 1'b0, 1'b0, 3'b100, 15'h00a0, 8'ha0 ^ 8'h3c);
        go(16'h213f, 1'b0, 1'b0, 3'b100, 15'h01ef, 8'hef ^ 8'h3c);
        // beyond the fourth bank nothing is implemented
        go(16'h2140, 1'b0, 1'b0, 3'b000, 15'h0000, 8'h00);
        go(16'h0001, 1'b0, 1'b0, 3'b000, 15'h0000, 8'h00);
        go(16'h0000, 1'b1, 1'b1, 3'b000, 15'h0000, 8'h00);
        go(16'h8456, 1'b1, 1'b0, 3'b001, 15'h0456, 8'h56 ^ 8'hc3);
        go(16'hf456, 1'b1, 1'b1, 3'b000, 15'h0000, 8'h00);
    endtask : t_indirect

    // watchdog sized well past the roughly 180 cycles of the run
    initial begin
        #200us;
        bad_count++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge I_CORE_CLK);
        I_RESET <= 1'b0;
        t_stack();
        t_wrap();
        t_indirect();
        test_done();
    end
endmodule : tb_return_stack_and_indirect_mapper
`default_nettype wire
